// ---- rtl/sram_port_pkg.sv ----
// Functional notes
// RULE1: memory holds 1,048,576 words of 16 bits, 20-bit word address.
// RULE2: low lane select gates bits 7..0, high lane select bits 15..8.
// RULE3: memory drives a lane only when selected, read enabled, strobe high.
// RULE4: controller holds write strobe high throughout every read.
// RULE5: memory holds old read data at least 10 ns after address change.
// RULE6: read data valid within 55/70 ns of chip select.
// RULE7: read data valid within 30/35 ns of output enable low.
// RULE8: lane data valid within 55/70 ns of lane select low.
// RULE9: controller presents address no later than selects become active.
// RULE10: memory floats bus within 20/25 ns of chip deselect.
// RULE11: memory floats bus within 20/25 ns of output enable high.
// RULE12: lane floats within 25/30 ns of its select high; both high is standby.
// RULE13: write happens only with chips selected, strobe low, a lane selected.
// RULE14: controller changes address only while strobe, selects and lanes idle.
// RULE15: controller keeps address valid 50/60 ns before write end.
// RULE16: controller keeps chip selects active 50/60 ns before write end.
// RULE17: controller drives write data 25/30 ns before write end.
// RULE18: controller may remove write data right at write end.
// RULE19: memory floats outputs within 20/25 ns of strobe falling.
// RULE20: write pulse exceeds turn-off delay plus data set-up time.
// RULE21: selects active at or after strobe fall keep outputs floating.
// RULE22: memory resumes driving no sooner than 5 ns after write end.
// RULE23: controller never drives bus while memory drives read data.
// RULE24: controller spaces reads at least 55/70 ns apart.
// RULE25: controller spaces writes 55/70 ns apart, strobe low 45/55 ns.
// RULE26: controller waits one read cycle after leaving data retention; the code acts on retention_exit only in ST_IDLE.
`default_nettype none
package sram_port_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PS = 5000;
  // slow grade figures, safe for both grades
  localparam int T_RC_NS = 70;
  localparam int T_AA_NS = 70;
  localparam int T_WC_NS = 70;
  localparam int T_AW_NS = 60;
  localparam int T_WP_NS = 55;
  localparam int T_DW_NS = 30;
  localparam int T_WHZ_NS = 25;
  localparam int T_OHZ_NS = 25;
  localparam int T_OW_NS = 5;
  function automatic int cyc_up(input int ns);
    return (ns * 1000 + CLK_PS - 1) / CLK_PS;
  endfunction
  localparam int RD_CYC = cyc_up(T_AA_NS) + 1;
  localparam int RC_CYC = cyc_up(T_RC_NS);
  localparam int WP_CYC = cyc_up(T_WP_NS > T_WHZ_NS + T_DW_NS ? T_WP_NS : T_WHZ_NS + T_DW_NS) + 1;
  localparam int WC_CYC = cyc_up(T_WC_NS);
  localparam int TURN_CYC = cyc_up(T_OHZ_NS > T_OW_NS ? T_OHZ_NS : T_OW_NS);
  localparam int CNT_W = 6;
endpackage
`default_nettype wire

// ---- rtl/sram_cycle_timer.sv ----
`default_nettype none
module sram_cycle_timer #(
  parameter int W = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  // done must not look at load: the sequencer loads on done, a loop otherwise
  assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// ---- rtl/sram_host_ctrl.sv ----
`default_nettype none
module sram_host_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  // user request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [sram_port_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sram_port_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic rsp_valid,
  output logic [sram_port_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic retention_exit,
  // memory pins
  output logic [sram_port_pkg::ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic chip_select_hi,
  output logic out_enable_n,
  output logic write_strobe_n,
  output logic low_lane_select_n,
  output logic high_lane_select_n,
  input wire logic [sram_port_pkg::DATA_W-1:0] data_bus_in,
  output logic [sram_port_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe
);
  import sram_port_pkg::*;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_READ = 6'b000100,
    ST_WRITE = 6'b001000,
    ST_RECOV = 6'b010000,
    ST_TURN = 6'b100000
  } state_e;

  state_e state_r, state_nxt;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  logic wr_r;
  logic read_done_r;
  logic read_sample;

  // selects and lanes go active only in the two access states
  function automatic logic in_access(input state_e s);
    return (s == ST_READ) || (s == ST_WRITE);
  endfunction

  sram_cycle_timer #(.W(CNT_W)) timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(load),
    .count(count),
    .done(done)
  );

  // retention exit wins over a same-cycle request
  assign req_ready = (state_r == ST_IDLE) && done && !retention_exit;

  always_comb begin
    state_nxt = state_r;
    load = 1'b0;
    count = '0;
    case (state_r)
      ST_IDLE: begin
        if (retention_exit) begin
          load = 1'b1; // RULE26
          count = CNT_W'(RC_CYC);
        end else if (req_valid && done) begin
          state_nxt = ST_SETUP; // RULE9
        end
      end
      ST_SETUP: begin
        load = 1'b1;
        if (wr_r) begin
          state_nxt = ST_WRITE;
          count = CNT_W'(WP_CYC); // RULE20 RULE25
        end else begin
          state_nxt = ST_READ;
          count = CNT_W'(RD_CYC);
        end
      end
      ST_READ: begin
        if (done) begin
          state_nxt = ST_TURN;
          load = 1'b1;
          count = CNT_W'(TURN_CYC); // RULE23 RULE24
        end
      end
      ST_WRITE: begin
        if (done) begin
          state_nxt = ST_RECOV;
          load = 1'b1;
          count = CNT_W'(WC_CYC - WP_CYC); // RULE25
        end
      end
      ST_RECOV: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TURN: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] wdata_r;
  logic [1:0] lanes_r;
  logic take;

  assign take = req_ready && req_valid;

  // address moves only on a take, while every select is idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_address <= '0;
    end else if (take) begin
      word_address <= req_addr; // RULE14 RULE15
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdata_r <= '0;
      lanes_r <= 2'b00;
      wr_r <= 1'b0;
    end else if (take) begin
      wdata_r <= req_wdata;
      lanes_r <= req_lanes;
      wr_r <= req_write;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: selects
  // ----------------------------------------------------------------
  // every control pin follows state_nxt, so all of them switch on one edge
  // address settles a cycle before any select: no address-access wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chip_select_n <= 1'b1;
      chip_select_hi <= 1'b0;
      low_lane_select_n <= 1'b1;
      high_lane_select_n <= 1'b1;
    end else begin
      chip_select_n <= !in_access(state_nxt); // RULE9 RULE16
      chip_select_hi <= in_access(state_nxt);
      low_lane_select_n <= !(in_access(state_nxt) && lanes_r[0]);
      high_lane_select_n <= !(in_access(state_nxt) && lanes_r[1]);
    end
  end

  // ----------------------------------------------------------------
  // pin drive: read and write enables
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      out_enable_n <= !(state_nxt == ST_READ); // RULE11
      write_strobe_n <= !(state_nxt == ST_WRITE); // RULE4
    end
  end

  // ----------------------------------------------------------------
  // pin drive: write data
  // ----------------------------------------------------------------
  // data leaves with the strobe edge: zero hold suffices, and the bus
  // is already free when a read's turnaround count starts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_bus_oe <= 1'b0;
      data_bus_out <= '0;
    end else begin
      data_bus_oe <= (state_nxt == ST_WRITE); // RULE17 RULE18 RULE23
      data_bus_out <= wdata_r;
    end
  end

  // ----------------------------------------------------------------
  // read capture
  // ----------------------------------------------------------------
  // sampled on the same edge that releases the selects
  assign read_sample = (state_r == ST_READ) && done;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_rdata <= '0;
    end else if (read_sample) begin
      rsp_rdata <= data_bus_in; // RULE6 RULE7 RULE8
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      read_done_r <= 1'b0;
    end else begin
      read_done_r <= read_sample;
    end
  end
  assign rsp_valid = read_done_r;
endmodule
`default_nettype wire

// ---- sim/sram_model.sv ----
`default_nettype none
module sram_model (
  input wire logic sys_clk,
  input wire logic [19:0] word_address,
  input wire logic chip_select_n,
  input wire logic chip_select_hi,
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_lane_select_n,
  input wire logic high_lane_select_n,
  input wire logic [15:0] data_bus_out,
  input wire logic data_bus_oe,
  output logic [15:0] data_bus_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [logic [19:0]];
  logic [15:0] rd = 16'hA5A5;
  logic [15:0] flt = 16'hA5A5;
  logic [3:0] age = 4'h0;
  wire logic sel = !chip_select_n && chip_select_hi;
  wire logic [1:0] lane = {!high_lane_select_n, !low_lane_select_n};
  // late data: garbage until 65 ns into the read
  wire logic rdo = sel && !out_enable_n &&
    write_strobe_n && age > 4'hC;
  always @(posedge sys_clk) begin
    flt <= ~flt;
    age <= (sel && !out_enable_n) ? age + 4'(age != 4'hF) : 4'h0;
    rd <= mem.exists(word_address) ? mem[word_address] : flt;
    if (sel && !write_strobe_n && data_bus_oe) begin
      if (lane[0]) mem[word_address][7:0] <= data_bus_out[7:0];
      if (lane[1]) mem[word_address][15:8] <= data_bus_out[15:8];
    end
  end
  // a floating lane shows a toggling pattern, never the last value
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign data_bus_in[i*8+:8] = (rdo && lane[i]) ? rd[i*8+:8] :
      data_bus_oe ? data_bus_out[i*8+:8] : flt[i*8+:8];
  end
endmodule
`default_nettype wire

// ---- sim/sram_host_ctrl_sva.sv ----
`default_nettype none
module sram_host_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [19:0] word_address,
  input wire logic chip_select_n,
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic data_bus_oe,
  input wire logic rsp_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_strobe_high: assert property (!out_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  a_addr_at_select: assert property ($fell(chip_select_n) |-> $stable(word_address))
    else $error("address late at select");
  a_addr_held: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(word_address))
    else $error("address moved while selected");
  a_no_bus_fight: assert property (!out_enable_n || !$past(out_enable_n) |-> !data_bus_oe)
    else $error("bus driven during read");
  a_strobe_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*8] ##1 !write_strobe_n[*4])
    else $error("write pulse short");
  a_cs_before_end: assert property ($rose(write_strobe_n) |-> !$past(chip_select_n, 12))
    else $error("select late before write end");
  a_addr_before_end: assert property ($rose(write_strobe_n) |-> word_address == $past(word_address, 12))
    else $error("address late before write end");
  a_data_setup: assert property ($rose(write_strobe_n) |-> $past(data_bus_oe) && $past(data_bus_oe, 6))
    else $error("write data set-up short");
  a_access_space: assert property ($fell(chip_select_n) |=> !$fell(chip_select_n)[*8] ##1 !$fell(chip_select_n)[*5])
    else $error("accesses too close");
  cover property ($rose(rsp_valid));
  cover property ($fell(write_strobe_n));
  cover property ($fell(out_enable_n));
endmodule
bind sram_host_ctrl sram_host_ctrl_chk u_chk (.*);
`default_nettype wire

// ---- sim/test_sram_host_ctrl.sv ----
`default_nettype none
module test_sram_host_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst = 1, req_valid = 0, req_write = 0, retention_exit = 0, req_ready, rsp_valid;
  logic [19:0] req_addr = 0, word_address;
  logic [15:0] req_wdata = 0, rsp_rdata, data_bus_in, data_bus_out;
  logic [1:0] req_lanes = 0;
  logic chip_select_n, chip_select_hi, out_enable_n, write_strobe_n, data_bus_oe;
  logic low_lane_select_n, high_lane_select_n;
  int fail_count = 0, n_checks = 0;
  sram_host_ctrl uut (.*);
  sram_model mem_m (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until the edge that sees ready high
  task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
      input logic [1:0] ln);
    int t;
    // one edge between calls: req_valid is never assigned twice in a step
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= ln;
    for (t = 0; t < 99; t++) begin
      @(posedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    if (t == 99) check("ready", 16'h0001, 16'h0000);
    if (t == 99) print_verdict();
  endtask
  task automatic read_chk(input logic [19:0] a, input logic [15:0] exp);
    int n;
    access(1'b0, a, 16'h0000, 2'h3);
    for (n = 1; n < 40; n++) begin
      @(posedge sys_clk);
      if (rsp_valid === 1'b1) break;
    end
    check("latency", 16'(n), 16'(sram_port_pkg::RD_CYC + 3));
    check("rdata", exp, rsp_rdata);
    if (n == 40) print_verdict();
  endtask
  task automatic t_lanes();
    access(1'b1, 20'hFFFFF, 16'hBEEF, 2'h3);
    read_chk(20'hFFFFF, 16'hBEEF);
    access(1'b1, 20'hFFFFF, 16'h1234, 2'h1);
    read_chk(20'hFFFFF, 16'hBE34);
    access(1'b1, 20'hFFFFF, 16'h5600, 2'h2);
    read_chk(20'hFFFFF, 16'h5634);
    access(1'b1, 20'h00000, 16'h0F0F, 2'h3);
    access(1'b1, 20'h00000, 16'hFFFF, 2'h0);
    read_chk(20'h00000, 16'h0F0F);
  endtask
  task automatic t_retention();
    int lo;
    int w;
    lo = 0;
    // the exit pulse only counts while the sequencer is idle
    for (w = 0; w < 99; w++) begin
      @(posedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    if (w == 99) check("ready", 16'h0001, 16'h0000);
    if (w == 99) print_verdict();
    retention_exit <= 1'b1;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    retention_exit <= 1'b0;
    req_valid <= 1'b0;
    repeat (15) begin
      @(posedge sys_clk);
      lo += int'(req_ready === 1'b0);
    end
    check("lockout", 16'(lo), 16'(sram_port_pkg::RC_CYC));
    read_chk(20'h00000, 16'h0F0F);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check("idle", {data_bus_oe, chip_select_hi, req_ready}, 16'h0001);
    t_lanes();
    t_retention();
    print_verdict();
  end
endmodule
`default_nettype wire
